// [core/clkbuf_ctrl.sv]
// Serial control register bank and output pair gating of the clock buffer.
// Assumes scl and sda arrive asynchronously and are much slower than clk;
// ref_clk is the output clock and is unrelated to clk.
`timescale 1ns/10ps
module clkbuf_ctrl
    import clkbuf_regs_pkg::*;
#(
    parameter logic [3:0] REVISION_CODE = 4'h2,  // Arbitrary value.
    parameter logic [3:0] MAKER_CODE    = 4'h5,  // Arbitrary value.
    parameter logic [7:0] DEVICE_CODE   = 8'h3c  // Arbitrary value.
) (
    // System clock and reset.
    input  wire logic      clk,
    input  wire logic      sys_rst,
    // Output clock domain.
    input  wire logic      ref_clk,
    // Serial bus pins.
    input  wire logic      scl_in,
    input  wire logic      sda_in,
    output logic           sda_out,
    output logic           sda_oe_n,
    // Control pins.
    input  wire logic      bandwidth_pin,
    input  wire logic      output_request_pin_pair1_n,
    input  wire logic      output_request_pin_pair4_n,
    // Loop settings and output pair gates.
    output loop_cfg_t      loop_cfg,
    output logic [5:0]     pair_active
);

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers.

    logic scl_s1, scl_s2, scl_s3;
    logic sda_s1, sda_s2, sda_s3;
    logic bw_s1, bw_s2;

    // Two stages before use; the third stage only serves edge detection.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            {scl_s1, scl_s2, scl_s3} <= 3'h7;
            {sda_s1, sda_s2, sda_s3} <= 3'h7;
            {bw_s1, bw_s2}           <= 2'h0;
        end else begin
            {scl_s1, scl_s2, scl_s3} <= {scl_in, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_s3} <= {sda_in, sda_s1, sda_s2};
            {bw_s1, bw_s2}           <= {bandwidth_pin, bw_s1};
        end
    end

    logic scl_rise, scl_fall, bus_start, bus_stop;

    // Start and stop are data edges while the clock stays high.
    assign scl_rise  = scl_s2 & ~scl_s3;
    assign scl_fall  = ~scl_s2 & scl_s3;
    assign bus_start = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
    assign bus_stop  = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;

////////////////////////////////////////////////////////////////////////////////
// Protocol engine and register file.

    smb_state_t st_reg, st_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [7:0] sh_reg, sh_next;
    logic [7:0] idx_reg, idx_next;
    logic       rd_reg, rd_next;
    logic       nack_reg, nack_next;
    logic       low_reg, low_next;
    logic [7:0] loop_reg, loop_next;
    logic [7:0] pair_reg, pair_next;
    logic [7:0] len_reg, len_next;
    logic       tx_state, byte_done, load_done;
    logic [7:0] rd_value;

    // Register read decode, shared by the transmitter and the checks.
    function automatic logic [7:0] read_reg(input logic [7:0] idx);
        case (idx)
            IDX_LOOP:   read_reg = loop_reg;
            IDX_PAIR:   read_reg = pair_reg;
            IDX_IDENT:  read_reg = {REVISION_CODE, MAKER_CODE};
            IDX_DEVICE: read_reg = DEVICE_CODE;
            IDX_LENGTH: read_reg = len_reg;
            default:    read_reg = 8'h00;
        endcase
    endfunction

    assign tx_state  = (st_reg == ST_TCOUNT) || (st_reg == ST_TDATA);
    assign byte_done = scl_fall && (cnt_reg == ACK_SLOT);
    assign load_done = scl_fall && (cnt_reg == ACK_DONE);
    assign rd_value  = read_reg(idx_reg);

    // Next state of the engine; all sda changes happen on falling scl.
    always_comb begin
        st_next   = st_reg;
        cnt_next  = cnt_reg;
        sh_next   = sh_reg;
        idx_next  = idx_reg;
        rd_next   = rd_reg;
        nack_next = nack_reg;
        low_next  = low_reg;
        loop_next = loop_reg;
        pair_next = pair_reg;
        len_next  = len_reg;
        if (bus_start) begin
            // A repeated start also lands here and keeps the index.
            st_next  = ST_ADDR;
            cnt_next = 4'h0;
            low_next = 1'b0;
        end else if (bus_stop) begin
            st_next  = ST_IDLE;
            cnt_next = 4'h0;
            low_next = 1'b0;
        end else if (st_reg != ST_IDLE) begin
            if (scl_rise) begin
                if (cnt_reg == ACK_SLOT) begin
                    nack_next = sda_s2;
                end else if (!tx_state) begin
                    sh_next = {sh_reg[6:0], sda_s2};
                end
                cnt_next = cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == ACK_SLOT) begin
                low_next = 1'b0;
                case (st_reg)
                    ST_ADDR: begin
                        if (sh_reg == ADDR_WRITE || sh_reg == ADDR_READ) begin
                            low_next = 1'b1;
                            rd_next  = (sh_reg == ADDR_READ);
                        end else begin
                            st_next = ST_IDLE;
                        end
                    end
                    ST_INDEX: begin
                        idx_next = sh_reg;
                        low_next = 1'b1;
                    end
                    ST_COUNT: begin
                        low_next = 1'b1;
                    end
                    ST_WDATA: begin
                        low_next = 1'b1;
                        idx_next = idx_reg + 8'h01;
                        case (idx_reg)
                            IDX_LOOP:   loop_next = sh_reg & LOOP_MASK;
                            IDX_PAIR:   pair_next = sh_reg & PAIR_MASK;
                            IDX_LENGTH: len_next  = sh_reg;
                            default:    ;
                        endcase
                    end
                    // Transmit states release sda for the host's answer.
                    default: ;
                endcase
            end else if (scl_fall && cnt_reg == ACK_DONE) begin
                cnt_next = 4'h0;
                low_next = 1'b0;
                case (st_reg)
                    ST_ADDR: begin
                        if (rd_reg) begin
                            st_next  = ST_TCOUNT;
                            sh_next  = len_reg;
                            low_next = ~len_reg[7];
                        end else begin
                            st_next = ST_INDEX;
                        end
                    end
                    ST_INDEX: st_next = ST_COUNT;
                    ST_COUNT: st_next = ST_WDATA;
                    ST_WDATA: st_next = ST_WDATA;
                    ST_TCOUNT, ST_TDATA: begin
                        if (nack_reg) begin
                            st_next = ST_IDLE;
                        end else begin
                            st_next  = ST_TDATA;
                            sh_next  = rd_value;
                            low_next = ~rd_value[7];
                            idx_next = idx_reg + 8'h01;
                        end
                    end
                    default: st_next = ST_IDLE;
                endcase
            end else if (scl_fall && tx_state) begin
                // Next data bit goes out while scl is low.
                sh_next  = {sh_reg[6:0], 1'b0};
                low_next = ~sh_reg[6];
            end
        end
    end

    // Engine and register storage.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg   <= ST_IDLE;
            cnt_reg  <= 4'h0;
            sh_reg   <= 8'h00;
            idx_reg  <= 8'h00;
            rd_reg   <= 1'b0;
            nack_reg <= 1'b0;
            low_reg  <= 1'b0;
            loop_reg <= LOOP_RESET;
            pair_reg <= PAIR_RESET;
            len_reg  <= LENGTH_RESET;
        end else begin
            st_reg   <= st_next;
            cnt_reg  <= cnt_next;
            sh_reg   <= sh_next;
            idx_reg  <= idx_next;
            rd_reg   <= rd_next;
            nack_reg <= nack_next;
            low_reg  <= low_next;
            loop_reg <= loop_next;
            pair_reg <= pair_next;
            len_reg  <= len_next;
        end
    end

    // Open drain: only ever pull low, never drive high.
    assign sda_out  = 1'b0;
    assign sda_oe_n = ~low_reg;

////////////////////////////////////////////////////////////////////////////////
// Loop settings.

    loop_cfg_t cfg_reg, cfg_next;

    // Pin control offers no bypass pin, so the loop then stays in use.
    always_comb begin
        cfg_next.pin_ctrl = loop_reg[BIT_PIN_SEL];
        if (loop_reg[BIT_PIN_SEL]) begin
            cfg_next.bw_high = bw_s2;
            cfg_next.loop_on = 1'b1;
        end else begin
            cfg_next.bw_high = loop_reg[BIT_BW_HIGH];
            cfg_next.loop_on = loop_reg[BIT_LOOP_ON];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cfg_reg <= 3'h7;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    assign loop_cfg = cfg_reg;

////////////////////////////////////////////////////////////////////////////////
// Output pair gating in the output clock domain.

    logic [5:0] gate_raw, gate_s1, gate_s2, act_reg, act_next;

    // Register bits are static levels, so a two-flop crossing is enough.
    // request pins gate pairs 1 and 4
    assign gate_raw = {pair_reg[5], ~output_request_pin_pair4_n,
                       pair_reg[3], pair_reg[2],
                       ~output_request_pin_pair1_n, pair_reg[0]};

    always_comb begin
        act_next = gate_s2;
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gate_s1 <= 6'h00;
            gate_s2 <= 6'h00;
            act_reg <= 6'h00;
        end else begin
            gate_s1 <= gate_raw;
            gate_s2 <= gate_s1;
            act_reg <= act_next;
        end
    end

    assign pair_active = act_reg;

////////////////////////////////////////////////////////////////////////////////
// Checks.

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_addr_write;
        byte_done && st_reg == ST_ADDR && sh_reg == ADDR_WRITE
            |=> low_reg && !rd_reg ##1 low_reg;
    endproperty
    a_addr_write: assert property (p_addr_write)
        else $error("write address not acknowledged");

    property p_addr_read;
        byte_done && st_reg == ST_ADDR && sh_reg == ADDR_READ
            |=> low_reg && rd_reg;
    endproperty
    a_addr_read: assert property (p_addr_read)
        else $error("read address not acknowledged");

    property p_index;
        byte_done && st_reg == ST_INDEX
            |=> low_reg && idx_reg == $past(sh_reg);
    endproperty
    a_index: assert property (p_index)
        else $error("index byte not taken");

    property p_count;
        byte_done && st_reg == ST_COUNT |=> low_reg && st_reg == ST_COUNT;
    endproperty
    a_count: assert property (p_count)
        else $error("byte count not acknowledged");

    property p_write_len;
        byte_done && st_reg == ST_WDATA && idx_reg == IDX_LENGTH
            |=> low_reg && len_reg == $past(sh_reg);
    endproperty
    a_write_len: assert property (p_write_len)
        else $error("data byte not stored");

    property p_ident;
        byte_done && st_reg == ST_WDATA
            && (idx_reg == IDX_IDENT || idx_reg == IDX_DEVICE)
            |=> low_reg && $stable(loop_reg) && $stable(pair_reg)
                && $stable(len_reg);
    endproperty
    a_ident: assert property (p_ident)
        else $error("identity write not ignored");

    property p_step;
        load_done && tx_state && !nack_reg
            |=> idx_reg == $past(idx_reg) + 8'h01;
    endproperty
    a_step: assert property (p_step)
        else $error("index did not advance");

    property p_len_first;
        load_done && st_reg == ST_ADDR && rd_reg
            |=> st_reg == ST_TCOUNT && sh_reg == $past(len_reg);
    endproperty
    a_len_first: assert property (p_len_first)
        else $error("read did not start with length");

    property p_data;
        load_done && st_reg == ST_TCOUNT && !nack_reg
            |=> st_reg == ST_TDATA && sh_reg == $past(rd_value)
                && low_reg == !$past(rd_value[7]);
    endproperty
    a_data: assert property (p_data)
        else $error("wrong register sent");

    property p_reserved;
        loop_reg[6:2] == 5'h00 && (pair_reg & ~PAIR_MASK) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit set");

    property p_reg_ctrl;
        !loop_reg[BIT_PIN_SEL] ##1 !loop_reg[BIT_PIN_SEL]
            |=> loop_cfg.bw_high == $past(loop_reg[BIT_BW_HIGH])
                && loop_cfg.loop_on == $past(loop_reg[BIT_LOOP_ON]);
    endproperty
    a_reg_ctrl: assert property (p_reg_ctrl)
        else $error("register control not applied");

    property p_pin_ctrl;
        loop_reg[BIT_PIN_SEL]
            |=> loop_cfg.pin_ctrl && loop_cfg.loop_on
                && loop_cfg.bw_high == $past(bw_s2);
    endproperty
    a_pin_ctrl: assert property (p_pin_ctrl)
        else $error("pin control not applied");

    property p_pair1_on;
        @(posedge ref_clk) disable iff (sys_rst)
        (!output_request_pin_pair1_n) [*3] |=> pair_active[1];
    endproperty
    a_pair1_on: assert property (p_pair1_on)
        else $error("pair 1 not enabled in time");

    property p_pair4_off;
        @(posedge ref_clk) disable iff (sys_rst)
        output_request_pin_pair4_n [*3] |=> !pair_active[4];
    endproperty
    a_pair4_off: assert property (p_pair4_off)
        else $error("pair 4 not disabled in time");

    c_write: cover property (byte_done && st_reg == ST_WDATA);
    c_read: cover property (load_done && st_reg == ST_TDATA && !nack_reg);
    c_nack: cover property (load_done && st_reg == ST_TDATA && nack_reg);
    c_reg_mode: cover property ($fell(loop_reg[BIT_PIN_SEL]));

endmodule // clkbuf_ctrl

// [shared/clkbuf_regs_pkg.sv]
// Constants, state names and carrier types of the clock buffer control bank.
// Assumes one SMBus-style serial slave and one output clock domain around it.
// Notes on behaviour
// - Write address byte d4 is acknowledged
// - Index byte sets start register, acknowledged
// - Write byte count is acknowledged
// - Data bytes fill N onward, each acknowledged
// - Read address byte d5 is acknowledged
// - Read sends readback length byte first
// - Then registers from N onward are sent
// - Bit 7 picks pins or register control
// - Bit 1 picks low or high bandwidth
// - Bit 0 clear bypasses the loop
// - Register 1 bits enable pairs 5,3,2,0
// - Reserved bits read zero, ignore writes
// - Registers 3 and 4 hold identity codes
// - Register 5 is readback length, reset 6
// - Bandwidth pin steers bandwidth under pin control
// - Low request pins enable pairs 1, 4
// - Pair follows request pin within 2-3 cycles
package clkbuf_regs_pkg;
    // Bus addresses with the direction bit in bit 0.
    localparam logic [7:0] ADDR_WRITE   = 8'hd4;
    localparam logic [7:0] ADDR_READ    = 8'hd5;
    // Register indices.
    localparam logic [7:0] IDX_LOOP     = 8'h00;
    localparam logic [7:0] IDX_PAIR     = 8'h01;
    localparam logic [7:0] IDX_FUNC     = 8'h02;
    localparam logic [7:0] IDX_IDENT    = 8'h03;
    localparam logic [7:0] IDX_DEVICE   = 8'h04;
    localparam logic [7:0] IDX_LENGTH   = 8'h05;
    // Field positions of the loop control register.
    localparam int         BIT_PIN_SEL  = 7;
    localparam int         BIT_BW_HIGH  = 1;
    localparam int         BIT_LOOP_ON  = 0;
    // Writable bits and power-up values.
    localparam logic [7:0] LOOP_MASK    = 8'h83;
    localparam logic [7:0] PAIR_MASK    = 8'h2d;
    localparam logic [7:0] LOOP_RESET   = 8'h83;
    localparam logic [7:0] PAIR_RESET   = 8'h2d;
    localparam logic [7:0] LENGTH_RESET = 8'h06;
    // Bit counter values: acknowledge slot and end of acknowledge.
    localparam logic [3:0] ACK_SLOT     = 4'h8;
    localparam logic [3:0] ACK_DONE     = 4'h9;
    // Output pair gating latency limit in output clock cycles.
    localparam int         REQ_LAT_MAX  = 3;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_INDEX, ST_COUNT, ST_WDATA, ST_TCOUNT, ST_TDATA
    } smb_state_t;

    typedef struct packed {
        logic pin_ctrl;
        logic bw_high;
        logic loop_on;
    } loop_cfg_t;
endpackage

// [test/clkbuf_ctrl_tb_top.sv]
// Self-checking bench of the clock buffer control bank.
// Assumes the host model in test/ and a pull-up on the serial data wire.
`timescale 1ns/10ps
module clkbuf_ctrl_tb_top;
    import clkbuf_regs_pkg::*;

    // Identity values handed to the design; all three are arbitrary.
    localparam logic [3:0] REV = 4'h7;
    localparam logic [3:0] MAKER = 4'h9;
    localparam logic [7:0] DEV = 8'ha5;
    localparam int LIMIT = 60000;

    logic       clk;
    logic       ref_clk;
    logic       sys_rst;
    logic       scl;
    logic       sda_low;
    wire logic  sda_wire;
    logic       sda_out;
    logic       sda_oe_n;
    logic       bandwidth_pin;
    logic       req1_n;
    logic       req4_n;
    loop_cfg_t  loop_cfg;
    logic [5:0] pair_active;
    int         fail_count = 0;
    int         check_count = 0;
    int         cycles = 0;

    // Open-drain wire: low if either party pulls, else the pull-up wins.
    assign sda_wire = ~(sda_low | (~sda_oe_n & ~sda_out));

    clkbuf_ctrl #(
        .REVISION_CODE(REV),
        .MAKER_CODE   (MAKER),
        .DEVICE_CODE  (DEV)
    ) clkbuf_ctrl_inst (
        .clk                       (clk),
        .sys_rst                   (sys_rst),
        .ref_clk                   (ref_clk),
        .scl_in                    (scl),
        .sda_in                    (sda_wire),
        .sda_out                   (sda_out),
        .sda_oe_n                  (sda_oe_n),
        .bandwidth_pin             (bandwidth_pin),
        .output_request_pin_pair1_n(req1_n),
        .output_request_pin_pair4_n(req4_n),
        .loop_cfg                  (loop_cfg),
        .pair_active               (pair_active)
    );

    smbus_host_model smbus_host_model_inst (
        .clk     (clk),
        .scl     (scl),
        .sda_low (sda_low),
        .sda_wire(sda_wire)
    );

    ////////////////////////////////////////////////////////////////////////
    // Two unrelated clocks; the output clock is offset to avoid alignment.
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        ref_clk = 1'b0;
        #7;
        forever #15 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic give_verdict();
        if (fail_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Expected queue holds the length byte first, then the register bytes.
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp[$]);
        logic [7:0] got[$];
        smbus_host_model_inst.block_read(idx, exp.size() - 1, got);
        check("read acks", 8'h01, {7'h0, smbus_host_model_inst.acked});
        foreach (exp[i]) check("read byte", exp[i], got[i]);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d[$]);
        smbus_host_model_inst.block_write(idx, d);
        check("write acks", 8'h01, {7'h0, smbus_host_model_inst.acked});
    endtask

    // Output gates settle within three output clock edges.
    task automatic pairs(input logic [5:0] exp);
        repeat (REQ_LAT_MAX) @(posedge ref_clk);
        #1;
        check("pair_active", {2'h0, exp}, {2'h0, pair_active});
    endtask

    // Hang guard: a run past the limit counts as a mismatch.
    always @(posedge clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        sys_rst = 1'b1;
        bandwidth_pin = 1'b1;
        req1_n = 1'b0;
        req4_n = 1'b0;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check("loop_cfg", 8'h07, {5'h0, loop_cfg});
        pairs(6'h3f);
        rd(8'h00, '{8'h06, 8'h83, 8'h2d, 8'h00, {REV, MAKER}, DEV, 8'h06});
        wr(8'h00, '{8'h00, 8'h24, 8'hff, 8'hff, 8'hff, 8'h03});
        @(posedge clk);
        #1;
        check("loop_cfg", 8'h00, {5'h0, loop_cfg});
        pairs(6'h36);
        rd(8'h00, '{8'h03, 8'h00, 8'h24, 8'h00});
        rd(8'h03, '{8'h03, {REV, MAKER}, DEV, 8'h03});
        smbus_host_model_inst.probe(8'ha0);
        check("foreign ack", 8'h00, {7'h0, smbus_host_model_inst.acked});
        @(posedge clk);
        req1_n <= 1'b1;
        req4_n <= 1'b1;
        pairs(6'h24);
        @(posedge clk);
        req4_n <= 1'b0;
        pairs(6'h34);
        wr(8'h00, '{8'h03});
        @(posedge clk);
        #1;
        check("loop_cfg", 8'h03, {5'h0, loop_cfg});
        wr(8'h00, '{8'h80});
        bandwidth_pin <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        check("loop_cfg", 8'h05, {5'h0, loop_cfg});
        rd(8'h05, '{8'h03, 8'h03, 8'h00, 8'h00});
        give_verdict();
    end
endmodule // clkbuf_ctrl_tb_top

// [test/smbus_host_model.sv]
// Behavioural SMBus host that drives the serial pins of the clock buffer.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/10ps
module smbus_host_model (
    // Timing reference.
    input  wire logic clk,
    // Serial pins.
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda_wire
);
    // Half period of scl in clk cycles, twice the minimum the slave needs.
    localparam int HALF = 16;

    // Cleared whenever an acknowledge slot expected low was seen high.
    logic acked;

    // Idle bus: both lines released.
    initial begin
        scl     = 1'b1;
        sda_low = 1'b0;
        acked   = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Data changes only while scl is low, so no false start or stop appears.
    task automatic bit_slot(input logic b, output logic r);
        wait_clk(4);
        sda_low <= ~b;
        wait_clk(HALF - 4);
        scl <= 1'b1;
        wait_clk(HALF);
        r = sda_wire;
        scl <= 1'b0;
    endtask

    // Start or repeated start: data falls while the clock is high.
    task automatic start_cond();
        wait_clk(4);
        sda_low <= 1'b0;
        wait_clk(HALF - 4);
        scl <= 1'b1;
        wait_clk(HALF);
        sda_low <= 1'b1;
        wait_clk(HALF);
        scl <= 1'b0;
    endtask

    // Stop: data rises while the clock is high, bus left idle.
    task automatic stop_cond();
        wait_clk(4);
        sda_low <= 1'b1;
        wait_clk(HALF - 4);
        scl <= 1'b1;
        wait_clk(HALF);
        sda_low <= 1'b0;
        wait_clk(HALF);
    endtask

    // Byte out, most significant bit first, then the slave's acknowledge.
    task automatic send_byte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_slot(b[i], r);
        bit_slot(1'b1, r);
        if (r !== 1'b0) acked = 1'b0;
    endtask

    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_slot(1'b1, r);
            b[i] = r;
        end
        bit_slot(last, r);
    endtask

    // Address probe used to show that foreign addresses are ignored.
    task automatic probe(input logic [7:0] addr);
        acked = 1'b1;
        start_cond();
        send_byte(addr);
        stop_cond();
    endtask

    task automatic block_write(input logic [7:0] idx, input logic [7:0] d[$]);
        acked = 1'b1;
        start_cond();
        send_byte(8'hd4);
        send_byte(idx);
        send_byte(8'(d.size()));
        foreach (d[i]) send_byte(d[i]);
        stop_cond();
    endtask

    task automatic block_read(input logic [7:0] idx, input int n,
                              output logic [7:0] q[$]);
        logic [7:0] b;
        acked = 1'b1;
        q = {};
        start_cond();
        send_byte(8'hd4);
        send_byte(idx);
        start_cond();
        send_byte(8'hd5);
        for (int i = 0; i <= n; i++) begin
            recv_byte(i == n, b);
            q.push_back(b);
        end
        stop_cond();
    endtask
endmodule // smbus_host_model
